/* File: rtl/pgdm_pkg.sv */
/*
 Constants for the position gear / droop monitor: register map, field
 positions, reset values and timing. Assumes a 25 MHz control clock.
*/
package pgdm_pkg;
	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] GEAR_NUM_ADDR = 8'h00;
	localparam logic [7:0] GEAR_DEN_ADDR = 8'h04;
	localparam logic [7:0] SMOOTH_ADDR = 8'h08;
	localparam logic [7:0] INPOS_ADDR = 8'h0C;
	localparam logic [7:0] EXCESS_ADDR = 8'h10;
	localparam logic [7:0] CTRL_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;
	localparam logic [7:0] DROOP_ADDR = 8'h1C;
	localparam logic [7:0] INT_STAT_ADDR = 8'h20;
	localparam logic [7:0] INT_EN_ADDR = 8'h24;
	localparam logic [7:0] INT_CLR_ADDR = 8'h28;
	// --------------------------------------------------------------
	// fields and reset values
	// --------------------------------------------------------------
	localparam int CTRL_CLR_MODE_BIT = 0;
	localparam int CTRL_FAULT_CLR_BIT = 1;
	localparam int CTRL_CODE_LSB = 8;
	localparam int ST_INPOS_BIT = 0;
	localparam int ST_FAULT_BIT = 1;
	localparam logic [14:0] GEAR_NUM_RST = 15'h0001;
	localparam logic [14:0] GEAR_DEN_RST = 15'h0001;
	localparam logic [15:0] SMOOTH_RST = 16'h0000;
	localparam logic [15:0] SMOOTH_MAX_MS = 16'hC350;
	localparam logic [14:0] INPOS_RST = 15'h0064;
	localparam logic [19:0] EXCESS_RST = 20'h09C40;
	localparam logic [19:0] EXCESS_OFF = 20'h0270F;
	localparam logic [7:0] CODE_INPOS_HI = 8'h24;
	localparam logic [7:0] CODE_INPOS_LO = 8'h88;
	localparam logic [31:0] REVS_PER_MIN_DIV = 32'h0000003C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int SMOOTH_TICK_US = 1000;
	localparam int SMOOTH_TICK_CYC = CLK_HZ / 1000000 * SMOOTH_TICK_US;
endpackage : pgdm_pkg

/* File: rtl/pgdm_top.sv */
/*
 Position gear / droop monitor: electronic gear with remainder carry,
 optional command smoothing, x4 quadrature feedback, deviation counter,
 in-position flag, error-excess fault, AXI4-Lite registers and irq.
 Assumes all pulse, encoder and clear inputs are synchronous to aclk.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
// Notes on behaviour
// - command pulses scaled by numerator over denominator
// - scaled command rate matches x4 feedback rate
// - feedback counted on every quadrature edge
// - smoothing time 0..50 s, zero bypasses
// - droop counts command minus feedback pulses
// - in-position while droop below width
// - terminal code 36 high, 136 low
// - droop above level raises fault, stops
// - level 9999 disables the excess fault
// - clear mode 0 clears on rising edge
`timescale 1ns/1ps
module pgdm_top import pgdm_pkg::*; #(
	parameter int TICK_CYC = SMOOTH_TICK_CYC
) (
	input wire logic aclk, // control clock
	input wire logic aresetn, // sync reset, active low
	input wire logic cmd_pulse, // command pulse train
	input wire logic cmd_dir, // 1 = reverse
	input wire logic enc_a, // encoder phase a
	input wire logic enc_b, // encoder phase b
	input wire logic deviation_clear_input, // droop clear
	output logic in_position_flag, // terminal output
	output logic position_error_excess_fault, // fault, stops drive
	output logic irq, // level interrupt
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready // read ready
);
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	logic [14:0] num_reg, den_reg, inpos_w_reg;
	logic [15:0] smooth_reg;
	logic [19:0] excess_reg;
	logic clr_mode_reg;
	logic [7:0] code_reg;
	logic [1:0] int_stat_reg, int_en_reg;
	logic signed [31:0] acc_reg, backlog_reg, frac_reg, droop_reg;
	logic [31:0] tick_reg;
	logic cmd_d_reg, clr_d_reg, a_d_reg, b_d_reg, inpos_reg;
	logic [7:0] awaddr_reg, araddr_reg;
	logic aw_have_reg, w_have_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	// --------------------------------------------------------------
	// electronic gear
	// --------------------------------------------------------------
	logic cmd_edge, tick;
	logic signed [1:0] gear_step, cmd_step, fb_step;
	logic signed [31:0] num_s, den_s, add_s, abs_droop, smooth_s;
	assign cmd_edge = cmd_pulse & ~cmd_d_reg;
	assign num_s = {17'h00000, num_reg};
	assign den_s = {17'h00000, den_reg};
	assign smooth_s = {16'h0000, smooth_reg};
	assign add_s = !cmd_edge ? 32'sh0 : (cmd_dir ? -num_s : num_s);

	always_comb begin
		gear_step = 2'sd0;
		if (den_reg != 15'h0000 && acc_reg >= den_s) begin
			gear_step = 2'sd1;
		end else if (den_reg != 15'h0000 && acc_reg <= -den_s) begin
			gear_step = -2'sd1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg <= 32'sh0;
			cmd_d_reg <= 1'b0;
		end else begin
			cmd_d_reg <= cmd_pulse;
			acc_reg <= acc_reg + add_s - 32'(gear_step) * den_s;
		end
	end

	// --------------------------------------------------------------
	// command smoothing, first-order lag in 1 ms steps
	// --------------------------------------------------------------
	assign tick = tick_reg == 32'(TICK_CYC - 1);
	always_comb begin
		cmd_step = 2'sd0;
		if (smooth_reg == 16'h0000) begin
			cmd_step = gear_step;
		end else if (frac_reg >= smooth_s && backlog_reg > 32'sh0) begin
			cmd_step = 2'sd1;
		end else if (frac_reg <= -smooth_s && backlog_reg < 32'sh0) begin
			cmd_step = -2'sd1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || smooth_reg == 16'h0000) begin
			tick_reg <= 32'h0;
			backlog_reg <= 32'sh0;
			frac_reg <= 32'sh0;
		end else begin
			tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
			backlog_reg <= backlog_reg + 32'(gear_step) - 32'(cmd_step);
			frac_reg <= frac_reg + (tick ? backlog_reg : 32'sh0) - 32'(cmd_step) * smooth_s;
		end
	end

	// --------------------------------------------------------------
	// x4 quadrature feedback and deviation counter
	// --------------------------------------------------------------
	always_comb begin
		fb_step = 2'sd0;
		if ((enc_a ^ a_d_reg) && !(enc_b ^ b_d_reg)) begin
			fb_step = (enc_a ^ enc_b) ? 2'sd1 : -2'sd1;
		end else if ((enc_b ^ b_d_reg) && !(enc_a ^ a_d_reg)) begin
			fb_step = (enc_a ^ enc_b) ? -2'sd1 : 2'sd1;
		end
	end

	logic clr_now;
	assign clr_now = clr_mode_reg ? deviation_clear_input
		: (deviation_clear_input & ~clr_d_reg);
	assign abs_droop = droop_reg[31] ? -droop_reg : droop_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			droop_reg <= 32'sh0;
			a_d_reg <= 1'b0;
			b_d_reg <= 1'b0;
			clr_d_reg <= 1'b0;
		end else begin
			a_d_reg <= enc_a;
			b_d_reg <= enc_b;
			clr_d_reg <= deviation_clear_input;
			if (clr_now) begin
				droop_reg <= 32'sh0;
			end else begin
				droop_reg <= droop_reg + 32'(cmd_step) - 32'(fb_step);
			end
		end
	end

	// --------------------------------------------------------------
	// in-position, terminal and fault
	// --------------------------------------------------------------
	logic fault_set, fault_clr;
	assign fault_set = excess_reg != EXCESS_OFF && abs_droop > {12'h000, excess_reg};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			inpos_reg <= 1'b0;
			in_position_flag <= 1'b0;
			position_error_excess_fault <= 1'b0;
		end else begin
			inpos_reg <= abs_droop < {17'h00000, inpos_w_reg};
			if (code_reg == CODE_INPOS_HI) begin
				in_position_flag <= inpos_reg;
			end else if (code_reg == CODE_INPOS_LO) begin
				in_position_flag <= ~inpos_reg;
			end else begin
				in_position_flag <= 1'b0;
			end
			if (fault_set) begin
				position_error_excess_fault <= 1'b1;
			end else if (fault_clr) begin
				position_error_excess_fault <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// interrupts: bit0 in-position reached, bit1 excess fault
	// --------------------------------------------------------------
	logic [1:0] ev, int_clr;
	logic inpos_d_reg;
	assign ev = {fault_set, inpos_reg & ~inpos_d_reg};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_reg <= 2'h0;
			inpos_d_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			inpos_d_reg <= inpos_reg;
			int_stat_reg <= (int_stat_reg & ~int_clr) | ev;
			irq <= |(int_stat_reg & int_en_reg);
		end
	end

	// --------------------------------------------------------------
	// AXI4-Lite slave
	// --------------------------------------------------------------
	function automatic logic [32:0] rd(input logic [7:0] a);
		unique case (a)
			GEAR_NUM_ADDR: rd = {18'h00000, num_reg};
			GEAR_DEN_ADDR: rd = {18'h00000, den_reg};
			SMOOTH_ADDR: rd = {17'h00000, smooth_reg};
			INPOS_ADDR: rd = {18'h00000, inpos_w_reg};
			EXCESS_ADDR: rd = {13'h0000, excess_reg};
			CTRL_ADDR: rd = {17'h00000, code_reg, 7'h00, clr_mode_reg};
			STATUS_ADDR: rd = {31'h00000000, position_error_excess_fault, inpos_reg};
			DROOP_ADDR: rd = {1'b0, droop_reg};
			INT_STAT_ADDR: rd = {31'h00000000, int_stat_reg};
			INT_EN_ADDR: rd = {31'h00000000, int_en_reg};
			INT_CLR_ADDR: rd = 33'h000000000;
			default: rd = 33'h100000000;
		endcase
	endfunction : rd

	logic do_wr;
	logic [32:0] old;
	logic [31:0] wv, m;
	assign do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign old = rd(awaddr_reg);
	assign m = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wv = (old[31:0] & ~m) | (wdata_reg & m);
	assign int_clr = (do_wr && awaddr_reg == INT_CLR_ADDR) ? wv[1:0] : 2'h0;
	assign fault_clr = do_wr && awaddr_reg == CTRL_ADDR && wv[CTRL_FAULT_CLR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= old[32] ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			num_reg <= GEAR_NUM_RST;
			den_reg <= GEAR_DEN_RST;
			smooth_reg <= SMOOTH_RST;
			inpos_w_reg <= INPOS_RST;
			excess_reg <= EXCESS_RST;
			clr_mode_reg <= 1'b0;
			code_reg <= CODE_INPOS_HI;
			int_en_reg <= 2'h0;
		end else if (do_wr) begin
			unique case (awaddr_reg)
				GEAR_NUM_ADDR: num_reg <= wv[14:0];
				GEAR_DEN_ADDR: den_reg <= wv[14:0];
				SMOOTH_ADDR: smooth_reg <= wv[15:0] > SMOOTH_MAX_MS ? SMOOTH_MAX_MS : wv[15:0];
				INPOS_ADDR: inpos_w_reg <= wv[14:0];
				EXCESS_ADDR: excess_reg <= wv[19:0];
				CTRL_ADDR: begin
					clr_mode_reg <= wv[CTRL_CLR_MODE_BIT];
					code_reg <= wv[CTRL_CODE_LSB +: 8];
				end
				INT_EN_ADDR: int_en_reg <= wv[1:0];
				default: ;
			endcase
		end
	end

	logic [32:0] rd_now;
	assign rd_now = rd(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			araddr_reg <= 8'h00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				araddr_reg <= s_axi_araddr;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_now[31:0];
				s_axi_rresp <= rd_now[32] ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_gear_needs_den: assert property (gear_step != 2'sd0 |-> den_reg != 15'h0000)
		else $error("gear step with zero denominator");
	a_gear_remainder: assert property (gear_step == 2'sd1 && !cmd_edge
		|=> acc_reg == $past(acc_reg) - $past(den_s))
		else $error("gear remainder not carried");
	a_smooth_bypass: assert property (smooth_reg == 16'h0000 |-> cmd_step == gear_step)
		else $error("smoothing not bypassed at zero");
	a_quad_edge: assert property ((enc_a != a_d_reg) != (enc_b != b_d_reg) |-> fb_step != 2'sd0)
		else $error("quadrature edge not counted");
	a_droop_track: assert property (!clr_now
		|=> droop_reg == $past(droop_reg) + 32'($past(cmd_step)) - 32'($past(fb_step)))
		else $error("droop does not track pulses");
	a_inpos_width: assert property (abs_droop < {17'h00000, inpos_w_reg} |=> inpos_reg)
		else $error("in-position flag missing");
	a_term_code: assert property (code_reg == CODE_INPOS_LO && $stable(code_reg)
		|=> in_position_flag == !$past(inpos_reg))
		else $error("terminal code 136 not inverted");
	a_fault_raise: assert property (excess_reg != EXCESS_OFF
		&& abs_droop > {12'h000, excess_reg} |=> position_error_excess_fault)
		else $error("excess fault not raised");
	a_fault_off: assert property (excess_reg == EXCESS_OFF && !position_error_excess_fault
		|=> !position_error_excess_fault)
		else $error("fault raised while disabled");
	a_clear_edge: assert property (!clr_mode_reg && deviation_clear_input
		&& !clr_d_reg |=> droop_reg == 32'sh0)
		else $error("droop not cleared on edge");
endmodule : pgdm_top

/* File: verification/pgdm_feed_model.sv */
/*
 Far-side model: command pulse source and quadrature encoder.
 Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ps
module pgdm_feed_model (
	input wire logic aclk, // control clock
	output logic cmd_pulse, // command pulse train
	output logic cmd_dir, // 1 = reverse
	output logic enc_a, // encoder phase a
	output logic enc_b // encoder phase b
);
	// ------------------------------------------------------------
	// pulse and encoder tasks
	// ------------------------------------------------------------
	logic [1:0] ph = 2'h0;
	initial begin
		cmd_pulse = 1'b0;
		cmd_dir = 1'b0;
		enc_a = 1'b0;
		enc_b = 1'b0;
	end
	// high one cycle, then low for gap cycles
	task automatic send(input int n, input int gap, input logic dir);
		for (int i = 0; i < n; i++) begin
			cmd_dir <= dir;
			cmd_pulse <= 1'b1;
			@(posedge aclk);
			cmd_pulse <= 1'b0;
			repeat (gap) @(posedge aclk);
		end
	endtask : send
	// gray steps, a leads b: four counted edges per line
	task automatic turn(input int n);
		for (int i = 0; i < n; i++) begin
			ph = ph + 2'h1;
			enc_a <= ph[1] ^ ph[0];
			enc_b <= ph[1];
			@(posedge aclk);
		end
	endtask : turn
endmodule : pgdm_feed_model

/* File: verification/tb.sv */
/*
 Self-checking bench for the gear / droop monitor.
 Assumes pgdm_pkg and pgdm_top; registers reached over AXI4-Lite.
*/
`timescale 1ns/1ps
module tb import pgdm_pkg::*;;
	// ------------------------------------------------------------
	// signals, clock, instances
	// ------------------------------------------------------------
	logic aclk = 1'b0, aresetn = 1'b0, dclr = 1'b0;
	logic cp, cd, ea, eb, inpos, fault, irq;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	initial forever #20 aclk = ~aclk;
	pgdm_top #(.TICK_CYC(10)) i_dut (.aclk(aclk), .aresetn(aresetn), .cmd_pulse(cp),
		.cmd_dir(cd), .enc_a(ea), .enc_b(eb), .deviation_clear_input(dclr),
		.in_position_flag(inpos), .position_error_excess_fault(fault), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pgdm_feed_model i_feed (.aclk(aclk), .cmd_pulse(cp), .cmd_dir(cd), .enc_a(ea), .enc_b(eb));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(RESP_OKAY), "write resp");
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic dr(input int e, input string m);
		repeat (8) @(posedge aclk);
		rd(DROOP_ADDR);
		chk(d, 32'(e), m);
	endtask : dr
	task automatic clr();
		dclr <= 1'b1;
		@(posedge aclk);
		dclr <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask : clr
	task automatic gear(input logic [31:0] n, input logic [31:0] q);
		wr(GEAR_NUM_ADDR, n);
		wr(GEAR_DEN_ADDR, q);
	endtask : gear
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	logic [7:0] ra[7] = '{GEAR_NUM_ADDR, GEAR_DEN_ADDR, SMOOTH_ADDR, INPOS_ADDR,
		EXCESS_ADDR, CTRL_ADDR, INT_EN_ADDR};
	logic [31:0] rv[7] = '{32'h1, 32'h1, 32'h0, 32'h64, 32'h9C40, 32'h2400, 32'h0};
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i]);
			chk(d, rv[i], "reset value");
		end
		rd(8'h2C);
		chk(d, 32'h0, "unmapped read data");
		chk(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
		$display("test reset done");
		i_feed.send(10, 2, 1'b0);
		dr(10, "droop 1:1");
		i_feed.turn(8);
		dr(2, "droop after feedback");
		chk(32'(inpos), 32'h1, "inpos default width");
		wr(INPOS_ADDR, 32'h2);
		repeat (8) @(posedge aclk);
		chk(32'(inpos), 32'h0, "inpos equal width");
		wr(INPOS_ADDR, 32'h3);
		repeat (8) @(posedge aclk);
		chk(32'(inpos), 32'h1, "inpos under width");
		wr(CTRL_ADDR, 32'h8800);
		repeat (8) @(posedge aclk);
		chk(32'(inpos), 32'h0, "inpos inverted");
		wr(CTRL_ADDR, 32'h0);
		repeat (8) @(posedge aclk);
		chk(32'(inpos), 32'h0, "inpos unrouted");
		wr(CTRL_ADDR, 32'h2400);
		clr();
		dr(0, "droop cleared");
		$display("test droop done");
		gear(32'h4, 32'h1);
		i_feed.send(5, 6, 1'b0);
		dr(20, "gear 4/1");
		clr();
		gear(32'h1, 32'h3);
		i_feed.send(7, 2, 1'b0);
		dr(2, "gear 1/3 part");
		i_feed.send(2, 2, 1'b0);
		dr(3, "gear 1/3 carry");
		gear(32'h1, 32'h1);
		i_feed.send(3, 2, 1'b1);
		dr(0, "reverse pulses");
		$display("test gear done");
		wr(INT_EN_ADDR, 32'h2);
		wr(EXCESS_ADDR, 32'(EXCESS_OFF));
		gear(32'h14, 32'h1);
		wr(INT_CLR_ADDR, 32'h1);
		i_feed.send(501, 21, 1'b0);
		dr(10020, "droop large");
		chk({30'h0, fault, irq}, 32'h0, "fault disabled");
		wr(EXCESS_ADDR, 32'd10020);
		repeat (6) @(posedge aclk);
		chk(32'(fault), 32'h0, "droop at level");
		wr(EXCESS_ADDR, 32'd10019);
		repeat (6) @(posedge aclk);
		chk({30'h0, fault, irq}, 32'h3, "fault raised");
		rd(INT_STAT_ADDR);
		chk(d, 32'h2, "int status");
		wr(INT_EN_ADDR, 32'h0);
		repeat (4) @(posedge aclk);
		chk(32'(irq), 32'h0, "irq masked");
		clr();
		wr(CTRL_ADDR, 32'h2402);
		wr(INT_CLR_ADDR, 32'h2);
		wr(INT_EN_ADDR, 32'h2);
		repeat (4) @(posedge aclk);
		chk({30'h0, fault, irq}, 32'h0, "fault cleared");
		$display("test fault done");
		gear(32'h1, 32'h1);
		wr(SMOOTH_ADDR, 32'h1);
		clr();
		i_feed.send(20, 2, 1'b0);
		rd(DROOP_ADDR);
		chk(32'(d < 32'd20), 32'h1, "smoothing lags");
		repeat (500) @(posedge aclk);
		dr(20, "smoothing settles");
		$display("test smoothing done");
		conclude();
	end
endmodule : tb
